// [src/eiie_pkg.sv]
// Purpose: Shared constants of the exit instruction-information encoder
// Assumes: APB slave with a 12-bit byte address and 32-bit data
// Notes:   Field positions are bit offsets into the 32-bit word
package eiie_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int         ADDR_W     = 12;
  localparam logic [11:0] OFF_INFO   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_CTRL   = 12'h008;

  // ----------------------------------------
  // Status and control bits
  // ----------------------------------------
  localparam int ST_VALID_BIT = 0;
  localparam int ST_KIND_BIT  = 1;
  localparam int ST_ERR_BIT   = 2;
  localparam int CT_EN_BIT    = 0;
  localparam int CT_EXT64_BIT = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] INFO_RST  = 32'h0000_0000;
  localparam logic        EN_RST    = 1'b1;
  localparam logic        EXT64_RST = 1'b1;

  // ----------------------------------------
  // Field positions in the information word
  // ----------------------------------------
  localparam int RND_DEST_LSB   = 3;
  localparam int RND_OPSZ_LSB   = 11;
  localparam int SG_SCALE_LSB   = 0;
  localparam int SG_ASZ_LSB     = 7;
  localparam int SG_MEMREG_BIT  = 10;
  localparam int SG_SEG_LSB     = 15;
  localparam int SG_IDX_LSB     = 18;
  localparam int SG_IDXINV_BIT  = 22;
  localparam int SG_BASE_LSB    = 23;
  localparam int SG_BASEINV_BIT = 27;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [3:0] REG_LEGACY_MAX = 4'h7;
  localparam logic [1:0] OPSZ_UNUSED    = 2'h3;
  localparam logic [1:0] SCALE_X8       = 2'h3;
  localparam logic [2:0] ASZ_64         = 3'h2;
  localparam logic [2:0] SEG_MAX        = 3'h5;

endpackage

// [src/eiie_top.sv]
// Purpose: Builds and holds the exit instruction-information word
// Assumes: Core pulses exit_strobe for one cycle with its fields valid
// Notes:   Illegal field values are zeroed and flagged, never encoded
`timescale 1ns/1ns

// What this block does
// - Random read: destination register in bits 6:3
// - Random read: operand size 12:11, never three
// - Structure group: index scaling in bits 1:0
// - Scaling ignored when index flagged absent
// - Structure group: address size 9:7, 0..2
// - Structure group: segment in 17:15, 0..5
// - Structure group: index register in 21:18
// - Bit 22 set when no index register
// - Structure group: base register in 26:23
// - Bit 27 set when no base register
module eiie_top (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [eiie_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Exit report from the core
  input  wire logic                        exit_strobe,
  input  wire logic                        exit_is_struct,
  input  wire logic [3:0]                  rnd_dest_reg,
  input  wire logic [1:0]                  rnd_op_size,
  input  wire logic [1:0]                  sg_scale,
  input  wire logic [2:0]                  sg_addr_size,
  input  wire logic [2:0]                  sg_segment,
  input  wire logic [3:0]                  sg_index_reg,
  input  wire logic                        sg_index_valid,
  input  wire logic [3:0]                  sg_base_reg,
  input  wire logic                        sg_base_valid,
  // Word to the core
  output logic      [31:0]                 info_word,
  output logic                             info_valid
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] info;
    logic        valid;
    logic        kind;
    logic        err;
    logic        en;
    logic        ext64;
    logic [31:0] rdata;
    logic        slverr;
    logic        cap_rnd_d;
    logic        cap_sg_d;
    logic        ext64_d;
  } eiie_state_type;

  eiie_state_type s_r;
  eiie_state_type s_nxt;
  logic [31:0]    word;
  logic           bad;
  logic           capture;
  logic           setup;
  logic           wr_acc;

  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign capture = exit_strobe & s_r.en;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    word  = '0;
    bad   = 1'b0;

    if (!exit_is_struct) begin
      // Wide registers only exist on 64-bit capable cores
      if (s_r.ext64 || rnd_dest_reg <= eiie_pkg::REG_LEGACY_MAX) begin
        word[eiie_pkg::RND_DEST_LSB +: 4] = rnd_dest_reg;
      end else begin
        bad = 1'b1;
      end
      if (rnd_op_size != eiie_pkg::OPSZ_UNUSED) begin
        word[eiie_pkg::RND_OPSZ_LSB +: 2] = rnd_op_size;
      end else begin
        bad = 1'b1;
      end
    end else begin
      // Scaling left zero without an index, software ignores it
      if (sg_index_valid) begin
        if (sg_scale != eiie_pkg::SCALE_X8 || s_r.ext64) begin
          word[eiie_pkg::SG_SCALE_LSB +: 2] = sg_scale;
        end else begin
          bad = 1'b1;
        end
      end
      if (sg_addr_size < eiie_pkg::ASZ_64 ||
          (sg_addr_size == eiie_pkg::ASZ_64 && s_r.ext64)) begin
        word[eiie_pkg::SG_ASZ_LSB +: 3] = sg_addr_size;
      end else begin
        bad = 1'b1;
      end
      word[eiie_pkg::SG_MEMREG_BIT] = 1'b0;
      if (sg_segment <= eiie_pkg::SEG_MAX) begin
        word[eiie_pkg::SG_SEG_LSB +: 3] = sg_segment;
      end else begin
        bad = 1'b1;
      end
      if (sg_index_valid) begin
        if (s_r.ext64 || sg_index_reg <= eiie_pkg::REG_LEGACY_MAX) begin
          word[eiie_pkg::SG_IDX_LSB +: 4] = sg_index_reg;
        end else begin
          bad = 1'b1;
        end
      end
      word[eiie_pkg::SG_IDXINV_BIT] = ~sg_index_valid;
      if (sg_base_valid) begin
        if (s_r.ext64 || sg_base_reg <= eiie_pkg::REG_LEGACY_MAX) begin
          word[eiie_pkg::SG_BASE_LSB +: 4] = sg_base_reg;
        end else begin
          bad = 1'b1;
        end
      end
      word[eiie_pkg::SG_BASEINV_BIT] = ~sg_base_valid;
    end

    // Register writes; valid and error status bits clear on a written one
    if (wr_acc) begin
      if (paddr == eiie_pkg::OFF_STATUS) begin
        if (pwdata[eiie_pkg::ST_VALID_BIT]) begin
          s_nxt.valid = 1'b0;
        end
        if (pwdata[eiie_pkg::ST_ERR_BIT]) begin
          s_nxt.err = 1'b0;
        end
      end else if (paddr == eiie_pkg::OFF_CTRL) begin
        s_nxt.en    = pwdata[eiie_pkg::CT_EN_BIT];
        s_nxt.ext64 = pwdata[eiie_pkg::CT_EXT64_BIT];
      end
    end

    // Capture after the clears so a same-cycle clear never loses a new exit
    if (capture) begin
      s_nxt.info  = word;
      s_nxt.valid = 1'b1;
      s_nxt.kind  = exit_is_struct;
      if (bad) begin
        s_nxt.err = 1'b1;
      end
    end

    // Delayed copies let the checks see the capture cycle
    s_nxt.cap_rnd_d = capture & ~exit_is_struct;
    s_nxt.cap_sg_d  = capture & exit_is_struct;
    s_nxt.ext64_d   = s_r.ext64;

    // Read data sampled in the setup cycle, served in the access
    if (setup) begin
      s_nxt.rdata  = '0;
      s_nxt.slverr = 1'b0;
      unique case (paddr)
        eiie_pkg::OFF_INFO: begin
          s_nxt.rdata = s_r.info;
        end
        eiie_pkg::OFF_STATUS: begin
          s_nxt.rdata[eiie_pkg::ST_VALID_BIT] = s_r.valid;
          s_nxt.rdata[eiie_pkg::ST_KIND_BIT]  = s_r.kind;
          s_nxt.rdata[eiie_pkg::ST_ERR_BIT]   = s_r.err;
        end
        eiie_pkg::OFF_CTRL: begin
          s_nxt.rdata[eiie_pkg::CT_EN_BIT]    = s_r.en;
          s_nxt.rdata[eiie_pkg::CT_EXT64_BIT] = s_r.ext64;
        end
        default: begin
          s_nxt.slverr = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r        <= '0;
      s_r.info   <= eiie_pkg::INFO_RST;
      s_r.en     <= eiie_pkg::EN_RST;
      s_r.ext64  <= eiie_pkg::EXT64_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready     = 1'b1;
  assign prdata     = s_r.rdata;
  assign pslverr    = s_r.slverr & psel & penable;
  assign info_word  = s_r.info;
  assign info_valid = s_r.valid;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic cap_rnd_d;
  logic cap_sg_d;
  logic ext64_d;

  assign cap_rnd_d = s_r.cap_rnd_d;
  assign cap_sg_d  = s_r.cap_sg_d;
  assign ext64_d   = s_r.ext64_d;

  AST_RND_DEST: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && !exit_is_struct && rnd_dest_reg <= eiie_pkg::REG_LEGACY_MAX)
    |=> info_word[6:3] == $past(rnd_dest_reg))
    else $error("destination register field wrong");

  AST_RND_WIDE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cap_rnd_d && !ext64_d |-> info_word[6] == 1'b0)
    else $error("wide register on a core without 64-bit support");

  AST_RND_OPSZ: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && !exit_is_struct) |=> info_word[12:11] != 2'h3 &&
    ($past(rnd_op_size) == 2'h3 || info_word[12:11] == $past(rnd_op_size)))
    else $error("operand size field wrong");

  AST_RND_UNDEF: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cap_rnd_d |-> info_word[2:0] == 3'h0 && info_word[10:7] == 4'h0 &&
    info_word[31:13] == 19'h0)
    else $error("undefined random-read bits not zero");

  AST_SG_UNDEF: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cap_sg_d |-> info_word[6:2] == 5'h0 && info_word[14:11] == 4'h0 &&
    info_word[31:28] == 4'h0)
    else $error("undefined structure-group bits not zero");

  AST_SG_SCALE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && exit_is_struct && sg_index_valid && sg_scale != 2'h3)
    |=> info_word[1:0] == $past(sg_scale))
    else $error("scaling field wrong");

  AST_SG_NOIDX: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && exit_is_struct && !sg_index_valid)
    |=> info_word[1:0] == 2'h0 && info_word[21:18] == 4'h0)
    else $error("fields without index register not zero");

  AST_SG_ASZ: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cap_sg_d |-> info_word[9:7] <= 3'h2 &&
    (ext64_d || info_word[9:7] != 3'h2))
    else $error("address size out of range");

  AST_SG_MEM: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cap_sg_d |-> !info_word[10])
    else $error("memory/register bit set");

  AST_SG_SEG: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && exit_is_struct) |=> info_word[17:15] <= 3'h5 &&
    ($past(sg_segment) > 3'h5 || info_word[17:15] == $past(sg_segment)))
    else $error("segment field wrong");

  AST_SG_IDX: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && exit_is_struct && sg_index_valid &&
     sg_index_reg <= eiie_pkg::REG_LEGACY_MAX)
    |=> info_word[21:18] == $past(sg_index_reg))
    else $error("index register field wrong");

  AST_SG_IDXINV: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && exit_is_struct) |=> info_word[22] == !$past(sg_index_valid))
    else $error("index invalid bit wrong");

  AST_SG_BASE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && exit_is_struct && sg_base_valid &&
     sg_base_reg <= eiie_pkg::REG_LEGACY_MAX)
    |=> info_word[26:23] == $past(sg_base_reg))
    else $error("base register field wrong");

  AST_SG_BASEINV: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (capture && exit_is_struct) |=> info_word[27] == !$past(sg_base_valid) &&
    info_valid)
    else $error("base invalid bit wrong");

  AST_SG_SCALE_WIDE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cap_sg_d && !ext64_d |-> info_word[1:0] != 2'h3)
    else $error("scale by eight on a core without 64-bit support");

  AST_SG_IDX_WIDE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cap_sg_d && !ext64_d |-> info_word[21] == 1'b0)
    else $error("wide index register on a core without 64-bit support");

  AST_SG_BASE_WIDE: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cap_sg_d && !ext64_d |-> info_word[26] == 1'b0)
    else $error("wide base register on a core without 64-bit support");

endmodule

// [testbench/eiie_sw_model.sv]
// Purpose: Monitor software model reading the exit word over APB
// Assumes: Slave may insert wait states; pready is polled
// Notes:   Only the bench watchdog ends a stuck wait
`timescale 1ns/1ns
module eiie_sw_model (
  // Clock
  input  wire logic                        clk_sys,
  // APB master
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic [eiie_pkg::ADDR_W-1:0]      paddr,
  output logic [31:0]                      pwdata,
  input  wire logic [31:0]                 prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Undefined fields masked, never trusted
  function automatic logic [31:0] usable(input logic [31:0] w);
    logic [31:0] v;
    v = w;
    if (v[22]) v[1:0] = 2'h0;
    if (v[22]) v[21:18] = 4'h0;
    if (v[27]) v[26:23] = 4'h0;
    return v;
  endfunction
endmodule

// [testbench/eiie_top_bench.sv]
// Purpose: Self-checking bench of the exit information encoder
// Assumes: Exit fields valid in the strobe cycle; word visible one cycle later
// Notes:   Undefined bits follow the zero-fill choice of the design
`timescale 1ns/1ns
module eiie_top_bench;
  logic        clk_sys, arst_n, exit_strobe, exit_is_struct, iv, bv, pslverr, pready;
  logic        psel, penable, pwrite, info_valid, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, info_word, r;
  logic [3:0]  rd, ix, bs;
  logic [1:0]  rs, sc;
  logic [2:0]  as, sg;
  int          n_mismatch, compares;

  eiie_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exit_strobe(exit_strobe), .exit_is_struct(exit_is_struct),
    .rnd_dest_reg(rd), .rnd_op_size(rs), .sg_scale(sc), .sg_addr_size(as),
    .sg_segment(sg), .sg_index_reg(ix), .sg_index_valid(iv), .sg_base_reg(bs),
    .sg_base_valid(bv), .info_word(info_word), .info_valid(info_valid));
  eiie_sw_model sw (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One exit: fields with the strobe, word checked a cycle later
  task automatic go(input logic st, input logic [3:0] d, input logic [1:0] s,
                    input logic [1:0] c, input logic [2:0] a, input logic [2:0] g,
                    input logic [3:0] x, input logic xv, input logic [3:0] b,
                    input logic bvl, input logic [31:0] exp);
    @(posedge clk_sys);
    exit_strobe <= 1'b1;
    exit_is_struct <= st;
    rd <= d; rs <= s; sc <= c; as <= a; sg <= g; ix <= x; iv <= xv; bs <= b; bv <= bvl;
    @(posedge clk_sys);
    exit_strobe <= 1'b0;
    #1;
    chk(info_word, exp);
  endtask

  function automatic logic [31:0] sgw(input int i);
    sgw = {4'h0, 1'(i == 4), (i == 4) ? 4'h0 : 4'(15 - i), 1'(i == 2),
           (i == 2) ? 4'h0 : 4'(i + 9), 3'(i), 4'h0, 1'b0, 3'(i % 3), 5'h00,
           (i == 2) ? 2'h0 : 2'(i % 4)};
  endfunction

  initial begin
    arst_n = 1'b0; exit_strobe = 1'b0; exit_is_struct = 1'b0; rd = 4'h0; rs = 2'h0;
    sc = 2'h0; as = 3'h0; sg = 3'h0; ix = 4'h0; iv = 1'b0; bs = 4'h0; bv = 1'b0;
    n_mismatch = 0;
    compares = 0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    sw.xfer(1'b0, eiie_pkg::OFF_INFO, 32'h0, r, e); chk(r, eiie_pkg::INFO_RST);
    sw.xfer(1'b0, eiie_pkg::OFF_CTRL, 32'h0, r, e); chk(r, 32'h0000_0003);
    for (int i = 0; i < 16; i++) begin
      go(1'b0, 4'(i), 2'(i % 3), 2'h3, 3'h7, 3'h7, 4'hF, 1'b1, 4'hF, 1'b1,
         {19'h0, 2'(i % 3), 4'h0, 4'(i), 3'h0});
    end
    go(1'b0, 4'h5, 2'h3, 2'h0, 3'h0, 3'h0, 4'h0, 1'b0, 4'h0, 1'b0, 32'h0000_0028);
    sw.xfer(1'b0, eiie_pkg::OFF_STATUS, 32'h0, r, e); chk(r, 32'h0000_0005);
    sw.xfer(1'b1, eiie_pkg::OFF_STATUS, 32'h5, r, e);
    sw.xfer(1'b0, eiie_pkg::OFF_STATUS, 32'h0, r, e); chk(r, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      go(1'b1, 4'h0, 2'h0, 2'(i % 4), 3'(i % 3), 3'(i), 4'(i + 9), 1'(i != 2),
         4'(15 - i), 1'(i != 4), sgw(i));
      chk(sw.usable(info_word), sgw(i));
    end
    go(1'b1, 4'h0, 2'h0, 2'h1, 3'h6, 3'h6, 4'h1, 1'b1, 4'h2, 1'b1,
       32'h0104_0001);
    sw.xfer(1'b0, eiie_pkg::OFF_INFO, 32'h0, r, e); chk(r, 32'h0104_0001);
    sw.xfer(1'b0, eiie_pkg::OFF_STATUS, 32'h0, r, e); chk(r, 32'h0000_0007);
    sw.xfer(1'b1, eiie_pkg::OFF_INFO, 32'hFFFF_FFFF, r, e); chk({31'h0, e}, 32'h0);
    sw.xfer(1'b0, 12'h00C, 32'h0, r, e); chk({r[30:0], e}, 32'h0000_0001);
    sw.xfer(1'b1, eiie_pkg::OFF_CTRL, 32'h2, r, e);
    go(1'b0, 4'h3, 2'h1, 2'h0, 3'h0, 3'h0, 4'h0, 1'b0, 4'h0, 1'b0, 32'h0104_0001);
    sw.xfer(1'b1, eiie_pkg::OFF_CTRL, 32'h1, r, e);
    go(1'b0, 4'h9, 2'h2, 2'h0, 3'h0, 3'h0, 4'h0, 1'b0, 4'h0, 1'b0, 32'h0000_1000);
    go(1'b1, 4'h0, 2'h0, 2'h3, 3'h2, 3'h3, 4'h8, 1'b1, 4'h1, 1'b1,
       32'h0081_8000);
    go(1'b1, 4'h0, 2'h0, 2'h2, 3'h1, 3'h5, 4'h3, 1'b1, 4'hC, 1'b1,
       32'h000E_8082);
    chk({31'h0, info_valid}, 32'h1);
    wrap_up();
  end

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule
